// *** crc_controller.sv ***
// Programmable CRC controller: registers, input FIFO, interrupt logic.
// Assumes the local register port master and a 250 MHz system clock.
//
// Overview of operation
// - Pointer counts FIFO words, at most sixteen.
// - Long polynomials limit FIFO to eight words.
// - Full flag set exactly while FIFO full.
// - Empty flag set exactly while FIFO empty.
// - Interrupt select picks empty or done timing.
// - Start bit runs shifter; zero stops it.
// - Data width is field plus one.
// - Polynomial length is field plus one.
// - Unimplemented configuration bits read as zero.
`default_nettype none

module crc_controller #(
  parameter int FIFO_DEPTH = crc_ctrl_pkg::FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [crc_ctrl_pkg::ADDR_W-1:0] i_addr,
  input wire logic [crc_ctrl_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [crc_ctrl_pkg::DATA_W-1:0] o_rdata,
  output logic o_irq
);
  import crc_ctrl_pkg::*;

  localparam int PTR_W = $clog2(FIFO_DEPTH);

  // Software-written control state
  logic shifter_start;
  logic irq_timing_select;
  logic lsb_first_select;
  width_cfg_type cfg;
  logic [DATA_W-1:0] poly;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  // FIFO storage and pointers
  logic [DATA_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] word_count;

  // Engine connections
  logic eng_busy;
  logic eng_done;
  logic [DATA_W-1:0] eng_crc;
  word_req_type eng_req;

  // Address decode
  wire wr_ctrl = i_wr && (i_addr == OFS_CTRL_STATUS);
  wire wr_cfg = i_wr && (i_addr == OFS_WIDTH_CFG);
  wire wr_data = i_wr && (i_addr == OFS_DATA_IN);
  wire wr_result = i_wr && (i_addr == OFS_RESULT);
  wire wr_poly = i_wr && (i_addr == OFS_POLY);
  wire wr_irq_status = i_wr && (i_addr == OFS_IRQ_STATUS);
  wire wr_irq_mask = i_wr && (i_addr == OFS_IRQ_MASK);

  wire long_poly = (cfg.poly_length > POLY_LENGTH_FIELD_SPLIT);
  wire [CNT_W-1:0] fifo_limit = long_poly ? FIFO_LIMIT_LONG : FIFO_LIMIT_SHORT;

  wire fifo_full_flag = (word_count >= fifo_limit);
  wire fifo_empty_flag = (word_count == '0);

  wire [CNT_W-1:0] valid_word_count = fifo_full_flag ? fifo_limit : word_count;

  // FIFO push/pop; a write into a full FIFO is dropped and flagged
  wire push = wr_data && !fifo_full_flag;
  wire overflow = wr_data && fifo_full_flag;
  wire pop = shifter_start && !eng_busy && !fifo_empty_flag;

  wire ev_fifo_drained = pop && (word_count == 5'h01) && !push;
  wire ev_shift_done = eng_done && fifo_empty_flag && !push;
  wire crc_event = irq_timing_select ? ev_fifo_drained : ev_shift_done;

  wire [IRQ_W-1:0] irq_set = {overflow, crc_event};
  wire [IRQ_W-1:0] irq_clear = wr_irq_status ? i_wdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clear) | irq_set;

  // Word handed to the engine
  assign eng_req.data = fifo_mem[rd_ptr];
  assign eng_req.lsb_first = lsb_first_select;

  // Read views of the registers
  wire [REG_W-1:0] ctrl_view = {3'h0, valid_word_count, fifo_full_flag, fifo_empty_flag,
    irq_timing_select, shifter_start, lsb_first_select, 3'h0};
  wire [REG_W-1:0] cfg_view = {3'h0, cfg.data_width, 3'h0, cfg.poly_length};

  // Read data selection; unmapped addresses read zero
  logic [DATA_W-1:0] read_mux;
  assign read_mux = (i_addr == OFS_CTRL_STATUS) ? {16'h0000, ctrl_view}
    : (i_addr == OFS_WIDTH_CFG) ? {16'h0000, cfg_view}
    : (i_addr == OFS_RESULT) ? eng_crc
    : (i_addr == OFS_POLY) ? poly
    : (i_addr == OFS_IRQ_STATUS) ? {30'h0, irq_status}
    : (i_addr == OFS_IRQ_MASK) ? {30'h0, irq_mask}
    : 32'h0000_0000;

  // Control register fields
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      shifter_start <= 1'b0;
      irq_timing_select <= 1'b0;
      lsb_first_select <= 1'b0;
    end else if (wr_ctrl) begin
      shifter_start <= i_wdata[BIT_START];
      irq_timing_select <= i_wdata[BIT_ISEL];
      lsb_first_select <= i_wdata[BIT_LSB_FIRST];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cfg <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg.data_width <= i_wdata[DATA_WIDTH_FIELD_LO +: 5];
      cfg.poly_length <= i_wdata[POLY_LENGTH_FIELD_LO +: 5];
    end
  end

  // Polynomial and interrupt mask
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      poly <= POLY_RESET;
      irq_mask <= '0;
    end else begin
      if (wr_poly) begin
        poly <= i_wdata;
      end
      if (wr_irq_mask) begin
        irq_mask <= i_wdata[IRQ_W-1:0];
      end
    end
  end

  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // FIFO storage write
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      fifo_mem[wr_ptr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      word_count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        word_count <= word_count + 5'h01;
      end else if (pop && !push) begin
        word_count <= word_count - 5'h01;
      end
    end
  end

  // Registered bus answer and interrupt line
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rdata <= '0;
      o_irq <= 1'b0;
    end else begin
      o_rdata <= i_rd ? read_mux : '0;
      o_irq <= |(irq_status & irq_mask);
    end
  end

  crc_shift_engine u_engine (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_run(shifter_start),
    .i_load(pop),
    .i_req(eng_req),
    .i_cfg(cfg),
    .i_poly(poly),
    .i_seed_wr(wr_result),
    .i_seed(i_wdata),
    .o_busy(eng_busy),
    .o_done(eng_done),
    .o_crc(eng_crc)
  );

  // Named steps used by the checks below
  sequence seq_last_pop;
    pop && (word_count == 5'h01) && !push;
  endsequence

  sequence seq_final_shift;
    eng_done && fifo_empty_flag && !push;
  endsequence

  sequence seq_cfg_read;
    i_rd && (i_addr == OFS_WIDTH_CFG);
  endsequence

  chk_count_max_short: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (valid_word_count <= FIFO_LIMIT_SHORT) && (word_count <= FIFO_LIMIT_SHORT))
    else $error("valid word count above sixteen");

  chk_pointer_read_view: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_rd && i_addr == OFS_CTRL_STATUS)
    |=> (o_rdata[VALID_WORD_COUNT_LO +: CNT_W] <= $past(fifo_limit))
      && ((o_rdata[VALID_WORD_COUNT_LO +: CNT_W] == $past(word_count)) || $past(fifo_full_flag)))
    else $error("pointer read back does not match the word count");

  chk_push_counts_up: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (push && !pop) |=> (word_count == $past(word_count) + 5'h01))
    else $error("word count did not grow on a push");

  chk_pop_counts_down: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (pop && !push) |=> (word_count == $past(word_count) - 5'h01))
    else $error("word count did not shrink on a load");

  chk_count_max_long: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (long_poly && wr_data && fifo_full_flag) |=> (word_count <= $past(word_count)))
    else $error("FIFO grew past the long polynomial limit");

  chk_pointer_long_cap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_rd && i_addr == OFS_CTRL_STATUS && long_poly && !wr_cfg)
    |=> (o_rdata[VALID_WORD_COUNT_LO +: CNT_W] <= FIFO_LIMIT_LONG))
    else $error("pointer reports more than eight words");

  chk_full_blocks_push: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (wr_data && fifo_full_flag && !pop) |=> $stable(word_count) && $stable(wr_ptr))
    else $error("push accepted while FIFO full");

  chk_full_read_view: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_rd && i_addr == OFS_CTRL_STATUS)
    |=> (o_rdata[BIT_FULL] == ($past(word_count) >= $past(fifo_limit))))
    else $error("full flag read back wrong");

  chk_overflow_flagged: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    overflow |=> irq_status[IRQ_OVERFLOW])
    else $error("write into a full FIFO was not flagged");

  chk_empty_after_last: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    seq_last_pop |=> fifo_empty_flag ##1 (fifo_empty_flag || $past(push)))
    else $error("empty flag not set after last word left");

  chk_empty_read_view: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_rd && i_addr == OFS_CTRL_STATUS)
    |=> (o_rdata[BIT_EMPTY] == ($past(word_count) == 5'h00)))
    else $error("empty flag read back wrong");

  chk_irq_early_select: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (irq_timing_select ##0 seq_last_pop) |=> irq_status[IRQ_CRC]
      ##1 (o_irq || !$past(irq_mask[IRQ_CRC]) || $past(wr_irq_status)))
    else $error("early interrupt missing when FIFO drained");

  chk_irq_late_select: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!irq_timing_select ##0 seq_final_shift) |=> irq_status[IRQ_CRC])
    else $error("late interrupt missing after final shift");

  chk_irq_late_not_early: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ((!irq_timing_select && !irq_status[IRQ_CRC]) ##0 seq_last_pop)
    |=> !irq_status[IRQ_CRC])
    else $error("late interrupt raised before shifting finished");

  chk_irq_line_follows: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    1'b1 |=> (o_irq == $past(|(irq_status & irq_mask))))
    else $error("interrupt line does not follow unmasked status");

  chk_start_loads_word: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (shifter_start && !eng_busy && !fifo_empty_flag) |=> eng_busy)
    else $error("start bit set but shifter did not load");

  chk_stop_holds_crc: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!shifter_start && !wr_result) |=> $stable(eng_crc))
    else $error("CRC changed while shifter was off");

  chk_stop_blocks_load: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!shifter_start && !eng_busy) |=> !eng_busy)
    else $error("shifter loaded a word while stopped");

  chk_msb_first_view: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (pop && !lsb_first_select) |=> !eng_req.lsb_first || $past(wr_ctrl))
    else $error("bit order changed without a control write");

  chk_cfg_write_lands: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_cfg |=> (cfg.data_width == $past(i_wdata[DATA_WIDTH_FIELD_LO +: 5]))
      && (cfg.poly_length == $past(i_wdata[POLY_LENGTH_FIELD_LO +: 5])))
    else $error("configuration write did not land");

  chk_cfg_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    seq_cfg_read |=> (o_rdata[15:13] == 3'h0) && (o_rdata[7:5] == 3'h0)
      && (o_rdata[DATA_W-1:REG_W] == 16'h0000))
    else $error("unimplemented configuration bits read nonzero");

  chk_cfg_reset_zero: assert property (@(posedge i_clk_sys)
    i_rst |=> (cfg == CFG_RESET) && (word_count == '0) && !shifter_start)
    else $error("configuration not zero after reset");
endmodule : crc_controller

`default_nettype wire

// *** crc_shift_engine.sv ***
// Shared definitions for the CRC controller and its serial shift engine.
// Assumes one 250 MHz system clock and a synchronous, active-high reset.
`default_nettype none

package crc_ctrl_pkg;
  // Datapath and bus widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int REG_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;
  localparam int IRQ_W = 2;

  // FIFO limits and the polynomial length field above which the FIFO is halved
  localparam logic [CNT_W-1:0] FIFO_LIMIT_SHORT = 5'h10;
  localparam logic [CNT_W-1:0] FIFO_LIMIT_LONG = 5'h08;
  localparam logic [4:0] POLY_LENGTH_FIELD_SPLIT = 5'h07;

  // Register word indices on the local port
  localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_WIDTH_CFG = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_DATA_IN = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_POLY = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h6;

  // Control/status field positions
  localparam int BIT_LSB_FIRST = 3;
  localparam int BIT_START = 4;
  localparam int BIT_ISEL = 5;
  localparam int BIT_EMPTY = 6;
  localparam int BIT_FULL = 7;
  localparam int VALID_WORD_COUNT_LO = 8;

  // Width/length configuration field positions
  localparam int DATA_WIDTH_FIELD_LO = 8;
  localparam int POLY_LENGTH_FIELD_LO = 0;

  // Interrupt status bits
  localparam int IRQ_CRC = 0;
  localparam int IRQ_OVERFLOW = 1;

  // Reset values and helper constants
  localparam logic [DATA_W-1:0] LEN_MASK_SEED = 32'hFFFF_FFFE;
  localparam logic [DATA_W-1:0] POLY_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CRC_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [4:0] data_width;
    logic [4:0] poly_length;
  } width_cfg_type;

  localparam width_cfg_type CFG_RESET = '{data_width: 5'h00, poly_length: 5'h00};

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic lsb_first;
  } word_req_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } shift_state_type;
endpackage : crc_ctrl_pkg

// Serial CRC shifter: one data bit per clock while running.
// Expects the word and its bit order in one load pulse while idle.
module crc_shift_engine (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic i_load,
  input wire crc_ctrl_pkg::word_req_type i_req,
  input wire crc_ctrl_pkg::width_cfg_type i_cfg,
  input wire logic [crc_ctrl_pkg::DATA_W-1:0] i_poly,
  input wire logic i_seed_wr,
  input wire logic [crc_ctrl_pkg::DATA_W-1:0] i_seed,
  output logic o_busy,
  output logic o_done,
  output logic [crc_ctrl_pkg::DATA_W-1:0] o_crc
);
  import crc_ctrl_pkg::*;

  shift_state_type state;
  logic [DATA_W-1:0] word;
  logic lsb_first;
  logic [4:0] bit_cnt;
  logic [DATA_W-1:0] crc;

  // Bit selection, feedback and length mask
  wire advance = (state == ST_SHIFT) && i_run;
  wire last_bit = (bit_cnt == i_cfg.data_width);
  wire [4:0] msb_index = i_cfg.data_width - bit_cnt;
  wire cur_bit = lsb_first ? word[bit_cnt] : word[msb_index];
  wire [DATA_W-1:0] len_mask = ~(LEN_MASK_SEED << i_cfg.poly_length);
  wire feedback = cur_bit ^ crc[i_cfg.poly_length];
  wire [DATA_W-1:0] shifted = {crc[DATA_W-2:0], 1'b0} ^ (feedback ? i_poly : CRC_RESET);
  wire [DATA_W-1:0] next_crc = shifted & len_mask;

  // State, counter and captured word
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state <= ST_IDLE;
      bit_cnt <= 5'h00;
      word <= CRC_RESET;
      lsb_first <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (i_load) begin
            state <= ST_SHIFT;
            word <= i_req.data;
            lsb_first <= i_req.lsb_first;
            bit_cnt <= 5'h00;
          end
        end
        ST_SHIFT: begin
          if (advance) begin
            bit_cnt <= bit_cnt + 5'h01;
            if (last_bit) begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // CRC register; a seed write wins over shifting
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      crc <= CRC_RESET;
    end else if (i_seed_wr) begin
      crc <= i_seed;
    end else if (advance) begin
      crc <= next_crc;
    end
  end

  assign o_busy = (state == ST_SHIFT);
  assign o_done = advance && last_bit;
  assign o_crc = crc;

  chk_first_bit_order: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state == ST_IDLE && i_load) |=> (cur_bit == ($past(i_req.lsb_first) ? $past(i_req.data[0])
      : $past(i_req.data[i_cfg.data_width]))))
    else $error("first shifted bit has the wrong order");

  chk_word_length_end: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (advance && bit_cnt == i_cfg.data_width) |=> (state == ST_IDLE))
    else $error("shifter did not stop after data width plus one bits");

  chk_poly_length_mask: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (advance && !i_seed_wr && $stable(i_cfg)) |=> ((crc & ~len_mask) == CRC_RESET))
    else $error("CRC bits above polynomial length are set");
endmodule : crc_shift_engine

`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the CRC controller: registers, FIFO flags, interrupts.
// Assumes crc_ctrl_pkg is compiled first; the bench alone drives the register port.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import crc_ctrl_pkg::*;

  logic i_clk_sys;
  logic i_rst;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [DATA_W-1:0] o_rdata;
  logic o_irq;
  logic rd_seen;
  logic [DATA_W-1:0] exp_q[$];
  int failures;
  int n_checks;
  int cycles;
  logic [DATA_W-1:0] seed;
  logic [DATA_W-1:0] word;
  logic [DATA_W-1:0] rnd;

  crc_controller crc_controller_inst (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_irq(o_irq)
  );

  // Clock at 250 MHz
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write strobe, released before the next access
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr

  // One-cycle read strobe; the expected word waits in the queue
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge i_clk_sys);
    exp_q.push_back(e);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : idle

  // Control/status view built from its fields
  function automatic logic [DATA_W-1:0] cv(input int cnt, input bit full, input bit empty,
                                          input bit isel, input bit start, input bit lsb);
    cv = (DATA_W'(cnt) << VALID_WORD_COUNT_LO) | (DATA_W'(full) << BIT_FULL) |
         (DATA_W'(empty) << BIT_EMPTY) | (DATA_W'(isel) << BIT_ISEL) |
         (DATA_W'(start) << BIT_START) | (DATA_W'(lsb) << BIT_LSB_FIRST);
  endfunction : cv

  // Bench reference: one word shifted into the CRC, bit order chosen
  function automatic logic [DATA_W-1:0] crc_word(input logic [DATA_W-1:0] crc,
      input logic [DATA_W-1:0] d, input int w, input int pl, input logic [DATA_W-1:0] poly,
      input bit lsb);
    logic b;
    logic fb;
    for (int i = 0; i <= w; i++) begin
      b = lsb ? d[i] : d[w-i];
      fb = b ^ crc[pl];
      crc = ((crc << 1) ^ (fb ? poly : '0)) & (32'hFFFF_FFFF >> (31 - pl));
    end
    return crc;
  endfunction : crc_word

  // Read data stands only in the cycle after the strobe
  always @(posedge i_clk_sys) begin
    if (rd_seen) begin
      check(o_rdata, exp_q.pop_front());
    end
    rd_seen <= i_rd;
  end

  // Hang guard
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    i_rst = 1'b1;
    i_addr = '0;
    i_wdata = '0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    rd_seen = 1'b0;
    failures = 0;
    n_checks = 0;
    cycles = 0;
    void'($urandom(32'h22DDCDF2));
    idle(10);
    i_rst <= 1'b0;
    // Reset view and unmapped index
    rd(OFS_CTRL_STATUS, cv(0, 0, 1, 0, 0, 0));
    rd(OFS_WIDTH_CFG, 32'h0000_0000);
    rd(4'hF, 32'h0000_0000);
    // Random config write, reserved bits read zero
    rnd = $urandom;
    wr(OFS_WIDTH_CFG, rnd);
    rd(OFS_WIDTH_CFG, rnd & 32'h0000_1F1F);
    // Short polynomial: sixteen words fill the FIFO
    wr(OFS_WIDTH_CFG, 32'h0000_0003);
    wr(OFS_CTRL_STATUS, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      wr(OFS_DATA_IN, $urandom);
      if (i == 0) rd(OFS_CTRL_STATUS, cv(1, 0, 0, 0, 0, 0));
    end
    rd(OFS_CTRL_STATUS, cv(16, 1, 0, 0, 0, 0));
    wr(OFS_DATA_IN, $urandom);
    rd(OFS_IRQ_STATUS, 32'h0000_0002);
    idle(2);
    #1 check({31'h0, o_irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h0000_0002);
    idle(2);
    #1 check({31'h0, o_irq}, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h0000_0002);
    idle(2);
    #1 check({31'h0, o_irq}, 32'h0);
    // Long polynomial caps pointer at eight
    wr(OFS_WIDTH_CFG, 32'h0000_0008);
    rd(OFS_CTRL_STATUS, cv(8, 1, 0, 0, 0, 0));
    wr(OFS_CTRL_STATUS, cv(0, 0, 0, 0, 1, 0));
    idle(16 * 3 + 6);
    rd(OFS_CTRL_STATUS, cv(0, 0, 1, 0, 1, 0));
    wr(OFS_CTRL_STATUS, 32'h0000_0000);
    for (int i = 0; i < 8; i++) wr(OFS_DATA_IN, $urandom);
    rd(OFS_CTRL_STATUS, cv(8, 1, 0, 0, 0, 0));
    wr(OFS_IRQ_STATUS, 32'h0000_0003);
    wr(OFS_DATA_IN, $urandom);
    rd(OFS_IRQ_STATUS, 32'h0000_0002);
    wr(OFS_CTRL_STATUS, cv(0, 0, 0, 0, 1, 0));
    idle(8 * 3 + 6);
    // CRC of one byte for each bit order and interrupt timing
    for (int k = 0; k < 4; k++) begin
      wr(OFS_WIDTH_CFG, 32'h0000_0707);
      wr(OFS_POLY, 32'h0000_0007);
      seed = $urandom & 32'hFF;
      wr(OFS_RESULT, seed);
      wr(OFS_IRQ_STATUS, 32'h0000_0003);
      wr(OFS_CTRL_STATUS, cv(0, 0, 0, k[1], 0, k[0]));
      word = $urandom & 32'hFF;
      wr(OFS_DATA_IN, word);
      idle(4);
      rd(OFS_CTRL_STATUS, cv(1, 0, 0, k[1], 0, k[0]));
      wr(OFS_CTRL_STATUS, cv(0, 0, 0, k[1], 1, k[0]));
      idle(2);
      rd(OFS_IRQ_STATUS, k[1] ? 32'h1 : 32'h0);
      idle(20);
      rd(OFS_IRQ_STATUS, 32'h0000_0001);
      rd(OFS_RESULT, crc_word(seed, word, 7, 7, 32'h7, k[0]));
    end
    idle(3);
    // Reset with the start bit still set returns every field to zero except the empty flag, which reads one
    i_rst <= 1'b1;
    idle(2);
    i_rst <= 1'b0;
    rd(OFS_WIDTH_CFG, 32'h0000_0000);
    rd(OFS_CTRL_STATUS, cv(0, 0, 1, 0, 0, 0));
    rd(OFS_IRQ_STATUS, 32'h0000_0000);
    idle(2);
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
